/* include/exc_vec_pkg.sv */
// exception vector selection: shared constants and carriers
package exc_vec_pkg;

  localparam int VEC_W = 20;
  localparam logic [19:0] VEC_PROGRAM = 20'h00700;
  localparam logic [19:0] VEC_FLOAT_UNAVAIL = 20'h00800;
  localparam logic [19:0] VEC_COUNTDOWN = 20'h00900;
  localparam logic [19:0] VEC_SYSCALL = 20'h00C00;
  localparam logic [19:0] VEC_TRACE = 20'h00D00;
  localparam logic [19:0] VEC_RESERVED_FP_ASSIST = 20'h00E00;
  localparam logic [19:0] VEC_RSV_A_LO = 20'h00A00;
  localparam logic [19:0] VEC_RSV_A_HI = 20'h00BFF;
  localparam logic [19:0] VEC_RSV_E_LO = 20'h00E10;
  localparam logic [19:0] VEC_RSV_E_HI = 20'h00FFF;
  localparam logic [19:0] VEC_INSTR_TRANSLATION_BUFFER_MISS = 20'h01000;
  localparam logic [19:0] VEC_DLOAD_MISS = 20'h01100;
  localparam logic [19:0] VEC_DSTORE_MISS = 20'h01200;
  localparam logic [19:0] VEC_NONE = 20'h00000;

  // saved machine state cause bit positions (program exception kinds)
  localparam int CAUSE_W = 4;
  localparam int CAUSE_FLOAT = 0;
  localparam int CAUSE_ILLEGAL = 1;
  localparam int CAUSE_PRIV = 2;
  localparam int CAUSE_TRAP = 3;
  localparam logic [3:0] CAUSE_NONE = 4'h0;

  localparam int SPR_W = 10;
  localparam int SPR_MSB = 9;
  localparam int DEC_MSB = 31;
  localparam logic [31:0] DEC_RESET = 32'h00000000;

  // machine state register bits that this block watches
  typedef struct packed {
    logic userModeBit;
    logic floatAvailableBit;
    logic floatExcMode0;
    logic floatExcMode1;
    logic externalInterruptEnable;
    logic singleStepBit;
    logic branchTraceBit;
  } machine_state_s;

  // status of the instruction at the completion point
  typedef struct packed {
    logic valid;
    logic isFloat;
    logic isPrivileged;
    logic isSpecialMove;
    logic sprFieldInvalid;
    logic [9:0] specialRegisterNumber;
    logic illegalOpcode;
    logic unimplemented;
    logic optionalAbsent;
    logic optionalNop;
    logic trapTaken;
    logic isSystemCall;
    logic isBranch;
    logic floatEnabledExc;
    logic moveToFloatStatus;
    logic moveExcAndEnable;
  } instr_status_s;

  typedef struct packed {
    logic fetchMiss;
    logic loadMiss;
    logic storeMiss;
    logic storeChangeNeeded;
  } translation_s;

  typedef enum logic [3:0] {
    EXC_NONE,
    EXC_INSTR_TRANSLATION_BUFFER,
    EXC_FLOAT_UNAVAIL,
    EXC_PROGRAM,
    EXC_SYSCALL,
    EXC_DLOAD,
    EXC_DSTORE,
    EXC_COUNTDOWN,
    EXC_TRACE
  } exc_kind_e;

  function automatic logic [19:0] vecOf(input exc_kind_e k);
    case (k)
      EXC_INSTR_TRANSLATION_BUFFER: vecOf = VEC_INSTR_TRANSLATION_BUFFER_MISS;
      EXC_FLOAT_UNAVAIL: vecOf = VEC_FLOAT_UNAVAIL;
      EXC_PROGRAM: vecOf = VEC_PROGRAM;
      EXC_SYSCALL: vecOf = VEC_SYSCALL;
      EXC_DLOAD: vecOf = VEC_DLOAD_MISS;
      EXC_DSTORE: vecOf = VEC_DSTORE_MISS;
      EXC_COUNTDOWN: vecOf = VEC_COUNTDOWN;
      EXC_TRACE: vecOf = VEC_TRACE;
      default: vecOf = VEC_NONE;
    endcase
  endfunction

  function automatic logic inReserved(input logic [19:0] v);
    inReserved = (v == VEC_RESERVED_FP_ASSIST)
      || (v >= VEC_RSV_A_LO && v <= VEC_RSV_A_HI)
      || (v >= VEC_RSV_E_LO && v <= VEC_RSV_E_HI);
  endfunction

endpackage

/* design/countdown_edge.sv */
// countdown timer msb rising-edge detector with pending latch
module countdown_edge
  import exc_vec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] countdownTimer,
  input wire logic taken,
  output logic pending
);

  logic msb_q;
  logic msb_d;
  logic pend_q;
  logic pend_d;

  always_comb
  begin
    msb_d = countdownTimer[DEC_MSB];
    // a fresh edge wins over the clear in the same cycle
    pend_d = (pend_q && !taken) || (!msb_q && countdownTimer[DEC_MSB]);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      msb_q <= DEC_RESET[DEC_MSB];
      pend_q <= 1'b0;
    end
    else
    begin
      msb_q <= msb_d;
      pend_q <= pend_d;
    end
  end

  assign pending = pend_q;

  a_edge_sets_pend: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!msb_q && countdownTimer[DEC_MSB]) |=> pending)
    else $error("countdown edge did not set pending");

endmodule

/* design/exception_vector_select.sv */
// exception detection and vector selection, offsets 00700 to 01200
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - program exceptions vector 00700, cause recorded
// - float enabled exception: mode bit and summary
// - summary set by float or move-to-status
// - illegal, unimplemented, absent-optional raise illegal
// - privileged instruction in user mode raises
// - invalid special move, msb and user raise
// - trap condition true raises trap exception
// - float op with float unavailable: 00800
// - countdown msb rise: 00900 when enabled
// - system call vectors 00C00 unless a fetch miss, float unavailable or program cause wins
// - trace 00D00 on single-step or branch-trace
// - never dispatch reserved vectors
// - fetch translation miss vectors 01000
// - load translation miss vectors 01100
// - store miss or change-bit needed: 01200
module exception_vector_select
  import exc_vec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire exc_vec_pkg::machine_state_s machineStateRegister,
  input wire exc_vec_pkg::instr_status_s instrStatus,
  input wire exc_vec_pkg::translation_s translation,
  input wire logic [31:0] countdownTimer,
  input wire logic clearFloatSummary,
  output logic excTake,
  output logic [19:0] excVector,
  output logic [3:0] savedMachineState,
  output logic floatEnabledSummary
);

  import exc_vec_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  logic take_q;
  logic take_d;
  logic [19:0] vec_q;
  logic [19:0] vec_d;
  logic [3:0] cause_q;
  logic [3:0] cause_d;
  logic fex_q;
  logic fex_d;
  exc_kind_e kind;
  logic decPending;
  logic decTaken;
  logic [3:0] progCause;
  logic floatUnavail;
  logic traceHit;

  countdown_edge u_countdown_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .countdownTimer(countdownTimer),
    .taken(decTaken),
    .pending(decPending)
  );

  //////////////////////////////////////////////////////////////////////////////
  // summary bit is sticky; hardware set wins over software clear
  always_comb
  begin
    fex_d = fex_q;
    if (clearFloatSummary)
    begin
      fex_d = 1'b0;
    end
    if (instrStatus.valid && (instrStatus.floatEnabledExc
        || (instrStatus.moveToFloatStatus && instrStatus.moveExcAndEnable)))
    begin
      fex_d = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    progCause = CAUSE_NONE;
    floatUnavail = instrStatus.valid && instrStatus.isFloat
      && !machineStateRegister.floatAvailableBit;
    if (instrStatus.valid)
    begin
      progCause[CAUSE_FLOAT] = (machineStateRegister.floatExcMode0
        || machineStateRegister.floatExcMode1) && fex_q;
      progCause[CAUSE_ILLEGAL] = (instrStatus.illegalOpcode || instrStatus.unimplemented
        || instrStatus.optionalAbsent) && !instrStatus.optionalNop;
      progCause[CAUSE_PRIV] = machineStateRegister.userModeBit
        && (instrStatus.isPrivileged
        || (instrStatus.isSpecialMove && instrStatus.sprFieldInvalid
        && instrStatus.specialRegisterNumber[SPR_MSB]));
      progCause[CAUSE_TRAP] = instrStatus.trapTaken;
    end
    traceHit = instrStatus.valid && (machineStateRegister.singleStepBit
      || (instrStatus.isBranch && machineStateRegister.branchTraceBit));
  end

  //////////////////////////////////////////////////////////////////////////////
  // fixed priority: fetch, instruction-caused, data, asynchronous, trace
  always_comb
  begin
    kind = EXC_NONE;
    if (translation.fetchMiss)
    begin
      kind = EXC_INSTR_TRANSLATION_BUFFER;
    end
    else if (floatUnavail)
    begin
      kind = EXC_FLOAT_UNAVAIL;
    end
    else if (progCause != CAUSE_NONE)
    begin
      kind = EXC_PROGRAM;
    end
    else if (instrStatus.valid && instrStatus.isSystemCall)
    begin
      kind = EXC_SYSCALL;
    end
    else if (translation.loadMiss)
    begin
      kind = EXC_DLOAD;
    end
    else if (translation.storeMiss || translation.storeChangeNeeded)
    begin
      kind = EXC_DSTORE;
    end
    else if (decPending && machineStateRegister.externalInterruptEnable)
    begin
      kind = EXC_COUNTDOWN;
    end
    else if (traceHit)
    begin
      kind = EXC_TRACE;
    end
    decTaken = (kind == EXC_COUNTDOWN);
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    take_d = (kind != EXC_NONE);
    vec_d = vecOf(kind);
    // reserved offsets cannot come out of the table; guard kept for safety
    if (inReserved(vec_d))
    begin
      take_d = 1'b0;
      vec_d = VEC_NONE;
    end
    cause_d = (kind == EXC_PROGRAM) ? progCause : CAUSE_NONE;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      take_q <= 1'b0;
      vec_q <= VEC_NONE;
      cause_q <= CAUSE_NONE;
      fex_q <= 1'b0;
    end
    else
    begin
      take_q <= take_d;
      vec_q <= vec_d;
      cause_q <= cause_d;
      fex_q <= fex_d;
    end
  end

  assign excTake = take_q;
  assign excVector = vec_q;
  assign savedMachineState = cause_q;
  assign floatEnabledSummary = fex_q;

  //////////////////////////////////////////////////////////////////////////////
  sequence s_fetch_miss;
    translation.fetchMiss;
  endsequence

  sequence s_take_instr_translation_buffer;
    excTake && excVector == VEC_INSTR_TRANSLATION_BUFFER_MISS;
  endsequence

  a_instr_translation_buffer_vector: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_fetch_miss |=> s_take_instr_translation_buffer)
    else $error("fetch miss did not vector to 01000");

  a_no_reserved: assert property (@(posedge core_clk) disable iff (!rst_n)
    excTake |-> !inReserved(excVector) && excVector != VEC_NONE)
    else $error("reserved vector dispatched");

  a_syscall_vec: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instrStatus.valid && instrStatus.isSystemCall && !translation.fetchMiss
     && !floatUnavail && progCause == CAUSE_NONE) |=> excVector == VEC_SYSCALL)
    else $error("system call not vectored");

  a_priv_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instrStatus.valid && instrStatus.isPrivileged && machineStateRegister.userModeBit
     && !translation.fetchMiss && !floatUnavail)
    |=> excVector == VEC_PROGRAM && savedMachineState[CAUSE_PRIV])
    else $error("privileged in user mode not raised");

  a_float_unavail: assert property (@(posedge core_clk) disable iff (!rst_n)
    (floatUnavail && !translation.fetchMiss) |=> excVector == VEC_FLOAT_UNAVAIL)
    else $error("float unavailable not vectored");

  a_fex_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instrStatus.valid && instrStatus.floatEnabledExc) |=> floatEnabledSummary)
    else $error("summary bit not set");

  a_cause_program: assert property (@(posedge core_clk) disable iff (!rst_n)
    (savedMachineState != CAUSE_NONE) |-> excTake && excVector == VEC_PROGRAM)
    else $error("cause recorded without program vector");

  //////////////////////////////////////////////////////////////////////////////
  // trace sits below every other source, so its check names them all
  sequence s_trace_only;
    instrStatus.valid && (machineStateRegister.singleStepBit
      || (instrStatus.isBranch && machineStateRegister.branchTraceBit))
      && !translation.fetchMiss && !floatUnavail && progCause == CAUSE_NONE
      && !instrStatus.isSystemCall && !translation.loadMiss
      && !translation.storeMiss && !translation.storeChangeNeeded
      && !(decPending && machineStateRegister.externalInterruptEnable);
  endsequence

  a_trace_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_trace_only |=> excTake && excVector == VEC_TRACE)
    else $error("trace not vectored");

  a_trace_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    excVector == VEC_TRACE |-> $past(machineStateRegister.singleStepBit
      || (instrStatus.isBranch && machineStateRegister.branchTraceBit)))
    else $error("trace taken without a trace bit");

  sequence s_store_only;
    (translation.storeMiss || translation.storeChangeNeeded) && !translation.loadMiss
      && !translation.fetchMiss && !floatUnavail && progCause == CAUSE_NONE
      && !(instrStatus.valid && instrStatus.isSystemCall);
  endsequence

  a_dstore_vec: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_store_only |=> excTake && excVector == VEC_DSTORE_MISS)
    else $error("store miss not vectored");

  sequence s_load_only;
    translation.loadMiss && !translation.fetchMiss && !floatUnavail
      && progCause == CAUSE_NONE && !(instrStatus.valid && instrStatus.isSystemCall);
  endsequence

  a_dload_vec: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_load_only |=> excTake && excVector == VEC_DLOAD_MISS)
    else $error("load miss not vectored");

  sequence s_countdown_only;
    decPending && machineStateRegister.externalInterruptEnable
      && !translation.fetchMiss && !floatUnavail && progCause == CAUSE_NONE
      && !(instrStatus.valid && instrStatus.isSystemCall) && !translation.loadMiss
      && !translation.storeMiss && !translation.storeChangeNeeded;
  endsequence

  a_countdown_vec: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_countdown_only |=> excTake && excVector == VEC_COUNTDOWN)
    else $error("countdown event not vectored");

  // the enable holds a pending event back, the edge detector does not
  a_countdown_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    excVector == VEC_COUNTDOWN |-> $past(machineStateRegister.externalInterruptEnable))
    else $error("countdown taken while disabled");

  //////////////////////////////////////////////////////////////////////////////
  // program causes are only hidden by a fetch miss or float unavailable
  sequence s_take_program;
    excTake && excVector == VEC_PROGRAM;
  endsequence

  sequence s_float_enabled;
    instrStatus.valid && floatEnabledSummary
      && (machineStateRegister.floatExcMode0 || machineStateRegister.floatExcMode1)
      && !translation.fetchMiss && !floatUnavail;
  endsequence

  a_float_enabled: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_float_enabled |=> s_take_program ##0 savedMachineState[CAUSE_FLOAT])
    else $error("float enabled exception not raised");

  sequence s_illegal_op;
    instrStatus.valid && !instrStatus.optionalNop && !translation.fetchMiss && !floatUnavail
      && (instrStatus.illegalOpcode || instrStatus.unimplemented || instrStatus.optionalAbsent);
  endsequence

  a_illegal_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_illegal_op |=> s_take_program ##0 savedMachineState[CAUSE_ILLEGAL])
    else $error("illegal instruction not raised");

  a_nop_not_illegal: assert property (@(posedge core_clk) disable iff (!rst_n)
    (instrStatus.valid && instrStatus.optionalNop) |=> !savedMachineState[CAUSE_ILLEGAL])
    else $error("no-op optional raised illegal");

  sequence s_bad_special_move;
    instrStatus.valid && instrStatus.isSpecialMove && instrStatus.sprFieldInvalid
      && instrStatus.specialRegisterNumber[SPR_MSB] && machineStateRegister.userModeBit
      && !translation.fetchMiss && !floatUnavail;
  endsequence

  a_spr_priv: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_bad_special_move |=> s_take_program ##0 savedMachineState[CAUSE_PRIV])
    else $error("invalid special move not raised");

  a_priv_user_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    savedMachineState[CAUSE_PRIV] |-> $past(machineStateRegister.userModeBit))
    else $error("privileged cause outside user mode");

  sequence s_trap_hit;
    instrStatus.valid && instrStatus.trapTaken && !translation.fetchMiss && !floatUnavail;
  endsequence

  a_trap_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_trap_hit |=> s_take_program ##0 savedMachineState[CAUSE_TRAP])
    else $error("trap condition not raised");

  // a quiet cycle leaves nothing behind for the fetch unit to misread
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    !excTake |-> excVector == VEC_NONE && savedMachineState == CAUSE_NONE)
    else $error("vector shown without a take");

endmodule

/* verif/exception_vector_select_tb.sv */
// self-checking bench for exception detection and vector selection
module exception_vector_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import exc_vec_pkg::*;
  typedef struct {
    machine_state_s m;
    instr_status_s s;
    translation_s t;
    logic [19:0] v;
    logic [3:0] c;
  } row_t;
  logic core_clk;
  logic rst_n;
  machine_state_s machine_state_register;
  instr_status_s ist;
  translation_s tr;
  logic [31:0] countdownTimer;
  logic clearFloatSummary;
  logic excTake;
  logic [19:0] excVector;
  logic [3:0] savedMachineState;
  logic floatEnabledSummary;
  int fail_count;
  int n_checks;
  int k;
  //////////////////////////////////////////////////////////////////////////////
  // msr bits: user,favail,fe0,fe1,ee,se,be; instr: valid 24, float 23, priv 22,
  // smove 21, sprinv 20, spr 19:10, ill 9, unimpl 8, optabs 7, optnop 6,
  // trap 5, sc 4, branch 3; translation: fetch,load,store,change
  row_t rows [24] = '{
    '{7'h20, 25'h1000010, 4'h0, VEC_SYSCALL, 4'h0},
    '{7'h20, 25'h1000200, 4'h0, VEC_PROGRAM, 4'h2},
    '{7'h20, 25'h1000100, 4'h0, VEC_PROGRAM, 4'h2},
    '{7'h20, 25'h1000080, 4'h0, VEC_PROGRAM, 4'h2},
    '{7'h20, 25'h10000C0, 4'h0, VEC_NONE, 4'h0},
    '{7'h60, 25'h1400000, 4'h0, VEC_PROGRAM, 4'h4},
    '{7'h20, 25'h1400000, 4'h0, VEC_NONE, 4'h0},
    '{7'h60, 25'h1380000, 4'h0, VEC_PROGRAM, 4'h4},
    '{7'h60, 25'h1300000, 4'h0, VEC_NONE, 4'h0},
    '{7'h20, 25'h1000020, 4'h0, VEC_PROGRAM, 4'h8},
    '{7'h00, 25'h1800000, 4'h0, VEC_FLOAT_UNAVAIL, 4'h0},
    '{7'h20, 25'h1800000, 4'h0, VEC_NONE, 4'h0},
    '{7'h20, 25'h0000000, 4'h8, VEC_INSTR_TRANSLATION_BUFFER_MISS, 4'h0},
    '{7'h20, 25'h0000000, 4'h4, VEC_DLOAD_MISS, 4'h0},
    '{7'h20, 25'h0000000, 4'h2, VEC_DSTORE_MISS, 4'h0},
    '{7'h20, 25'h0000000, 4'h1, VEC_DSTORE_MISS, 4'h0},
    '{7'h22, 25'h1000000, 4'h0, VEC_TRACE, 4'h0},
    '{7'h21, 25'h1000008, 4'h0, VEC_TRACE, 4'h0},
    '{7'h21, 25'h1000000, 4'h0, VEC_NONE, 4'h0},
    '{7'h20, 25'h1000010, 4'h8, VEC_INSTR_TRANSLATION_BUFFER_MISS, 4'h0},
    '{7'h00, 25'h1800020, 4'h0, VEC_FLOAT_UNAVAIL, 4'h0},
    '{7'h20, 25'h1000030, 4'h0, VEC_PROGRAM, 4'h8},
    '{7'h20, 25'h1000010, 4'h4, VEC_SYSCALL, 4'h0},
    '{7'h22, 25'h1000000, 4'h1, VEC_DSTORE_MISS, 4'h0}
  };
  //////////////////////////////////////////////////////////////////////////////
  exception_vector_select i_exception_vector_select (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .machineStateRegister(machine_state_register),
    .instrStatus(ist),
    .translation(tr),
    .countdownTimer(countdownTimer),
    .clearFloatSummary(clearFloatSummary),
    .excTake(excTake),
    .excVector(excVector),
    .savedMachineState(savedMachineState),
    .floatEnabledSummary(floatEnabledSummary)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one row: launch after an edge, sampled at the next, looked at mid-cycle
  task automatic apply(input machine_state_s m, input instr_status_s s,
    input translation_s t);
    @(posedge core_clk);
    machine_state_register <= m;
    ist <= s;
    tr <= t;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic test_done();
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a reserved offset must never show, whatever the stimulus
  always @(negedge core_clk)
  begin
    if (excVector == VEC_RESERVED_FP_ASSIST
      || (excVector >= VEC_RSV_A_LO && excVector <= VEC_RSV_A_HI)
      || (excVector >= VEC_RSV_E_LO && excVector <= VEC_RSV_E_HI))
      chk(excVector, VEC_NONE);
  end
  // whole run is near 80 cycles, so 2000 means a hang
  initial
  begin
    #200000;
    fail_count++;
    test_done();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    machine_state_register = 7'h20;
    ist = '0;
    tr = '0;
    countdownTimer = 32'h00000000;
    clearFloatSummary = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk(excTake, 1'b0);
    chk(floatEnabledSummary, 1'b0);
    foreach (rows[i])
    begin
      apply(rows[i].m, rows[i].s, rows[i].t);
      chk(excVector, rows[i].v);
      chk(savedMachineState, rows[i].c);
      chk(excTake, rows[i].v != VEC_NONE);
    end
    // summary stays clear while no enable bit matches
    apply(7'h20, 25'h1000002, 4'h0);
    chk(floatEnabledSummary, 1'b0);
    apply(7'h20, 25'h1000004, 4'h0);
    chk(floatEnabledSummary, 1'b1);
    chk(excTake, 1'b0);
    apply(7'h28, 25'h1000000, 4'h0);
    chk(excVector, VEC_PROGRAM);
    chk(savedMachineState, 4'h1);
    @(posedge core_clk);
    clearFloatSummary <= 1'b1;
    machine_state_register <= 7'h20;
    ist <= '0;
    @(posedge core_clk);
    clearFloatSummary <= 1'b0;
    @(negedge core_clk);
    chk(floatEnabledSummary, 1'b0);
    // clear and a fresh set in one cycle: the set must win
    @(posedge core_clk);
    clearFloatSummary <= 1'b1;
    ist <= 25'h1000004;
    @(posedge core_clk);
    ist <= '0;
    @(negedge core_clk);
    chk(floatEnabledSummary, 1'b1);
    @(posedge core_clk);
    clearFloatSummary <= 1'b0;
    @(negedge core_clk);
    chk(floatEnabledSummary, 1'b0);
    apply(7'h20, 25'h1000003, 4'h0);
    chk(floatEnabledSummary, 1'b1);
    apply(7'h30, 25'h1000000, 4'h0);
    chk(savedMachineState, 4'h1);
    // reset in mid-run drops the sticky summary
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    machine_state_register <= 7'h20;
    ist <= '0;
    @(negedge core_clk);
    chk(floatEnabledSummary, 1'b0);
    chk(excTake, 1'b0);
    // countdown event waits for the enable, then fires once
    @(posedge core_clk);
    countdownTimer <= 32'h80000000;
    repeat (5)
    begin
      @(negedge core_clk);
      chk(excTake, 1'b0);
    end
    @(posedge core_clk);
    machine_state_register <= 7'h24;
    k = 0;
    @(negedge core_clk);
    while (excTake !== 1'b1 && k < 4)
    begin
      @(negedge core_clk);
      k++;
    end
    chk(excVector, VEC_COUNTDOWN);
    repeat (3)
    begin
      @(negedge core_clk);
      chk(excTake, 1'b0);
    end
    test_done();
  end
endmodule
